// *** pkg/spmbc_pkg.sv ***
// Package for the serial port mode and baud control block.
// Assumes a single 250 MHz clock domain and a plain register port.
package spmbc_pkg;
    localparam logic [7:0] SERIAL_CTRL_ADDR = 8'h98;
    localparam logic [7:0] POWER_CTRL_ADDR  = 8'h87;
    localparam logic [7:0] CLK_SEL_ADDR     = 8'hc8;
    localparam logic [7:0] SERIAL_CTRL_RST  = 8'h00;
    localparam logic [7:0] POWER_CTRL_RST   = 8'h00;
    localparam logic [1:0] CLK_SEL_RST      = 2'h0;
    localparam int BIT_MODE_HI     = 7;
    localparam int BIT_MODE_LO     = 6;
    localparam int BIT_MULTIPROC   = 5;
    localparam int BIT_RX_ENABLE   = 4;
    localparam int BIT_TX_NINTH    = 3;
    localparam int BIT_RX_NINTH    = 2;
    localparam int BIT_TX_DONE     = 1;
    localparam int BIT_RX_DONE     = 0;
    localparam int BIT_BAUD_DOUBLE = 7;
    localparam int BIT_TX_CLK_SEL  = 0;
    localparam int BIT_RX_CLK_SEL  = 1;
    localparam int MODE0_DIV       = 12;
    localparam int MODE2_DIV_FAST  = 32;
    localparam int MODE2_DIV_SLOW  = 64;
    localparam int T1_OVF_PER_BIT  = 32;
    localparam int T2_OVF_PER_BIT  = 16;
    localparam int SAMPLE_PER_BIT  = 16;
    localparam int DATA_BITS       = 8;

    typedef enum logic [1:0] {
        SPMBC_MODE_SHIFT,
        SPMBC_MODE_UART8,
        SPMBC_MODE_UART9_FIXED,
        SPMBC_MODE_UART9_VAR
    } spmbc_mode_e;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } spmbc_bus_s;
endpackage

// *** hw/spmbc_serial_port.sv ***
// Serial port mode decode, baud tick generation, frame shifting and status flags.
// Assumes timer overflow pulses are one-cycle pulses on CLK; RXD is an asynchronous pin.
`timescale 1ns/1ps
`default_nettype none
module spmbc_serial_port (
    input  wire logic       CLK,
    input  wire logic       RST_N,
    input  wire logic [7:0] ADDR,
    input  wire logic [7:0] WDATA,
    input  wire logic       WR,
    input  wire logic       RD,
    output logic      [7:0] RDATA,
    input  wire logic       T1_OVF,
    input  wire logic       T2_OVF,
    input  wire logic       RXD_IN,
    output logic            RXD_OUT,
    output logic            RXD_OE_N,
    output logic            TXD
);
    ////////////////////////////////////////////////////////////////////////////
    spmbc_pkg::spmbc_bus_s bus;
    assign bus = '{wr: WR, rd: RD, addr: ADDR, wdata: WDATA};

    logic [7:0] ctrl_ff, nxt_ctrl;
    logic [7:0] pwr_ff;
    logic [1:0] csel_ff;
    logic [7:0] rdata_ff, nxt_rdata;
    wire        sel_ctrl = bus.addr == spmbc_pkg::SERIAL_CTRL_ADDR;
    wire        sel_pwr  = bus.addr == spmbc_pkg::POWER_CTRL_ADDR;
    wire        sel_csel = bus.addr == spmbc_pkg::CLK_SEL_ADDR;
    wire        sel_tdat = bus.addr == spmbc_pkg::CLK_SEL_ADDR + 8'h01;
    wire        wr_ctrl  = bus.wr && sel_ctrl;
    wire        wr_pwr   = bus.wr && sel_pwr;
    wire        wr_csel  = bus.wr && sel_csel;

    spmbc_pkg::spmbc_mode_e mode;
    assign mode = spmbc_pkg::spmbc_mode_e'(ctrl_ff[spmbc_pkg::BIT_MODE_HI:spmbc_pkg::BIT_MODE_LO]);
    wire filt    = ctrl_ff[spmbc_pkg::BIT_MULTIPROC];
    wire rx_en   = ctrl_ff[spmbc_pkg::BIT_RX_ENABLE];
    wire dbl     = pwr_ff[spmbc_pkg::BIT_BAUD_DOUBLE];
    wire tx_t2   = csel_ff[spmbc_pkg::BIT_TX_CLK_SEL];
    wire rx_t2   = csel_ff[spmbc_pkg::BIT_RX_CLK_SEL];

    ////////////////////////////////////////////////////////////////////////////
    // Baud ticks: 16 sample ticks per bit in the UART modes.
    logic [5:0] pre_ff;
    logic       t1_half_ff;
    wire        osc_top  = pre_ff == 6'(spmbc_pkg::MODE2_DIV_SLOW / spmbc_pkg::SAMPLE_PER_BIT - 1);
    wire        osc_tick = dbl ? pre_ff[0] : osc_top;
    wire        t1_tick  = T1_OVF && (dbl || t1_half_ff);
    wire        tx_var   = tx_t2 ? T2_OVF : t1_tick;
    wire        rx_var   = rx_t2 ? T2_OVF : t1_tick;
    wire        tx_tick  = mode == spmbc_pkg::SPMBC_MODE_UART9_FIXED ? osc_tick : tx_var;
    wire        rx_tick  = mode == spmbc_pkg::SPMBC_MODE_UART9_FIXED ? osc_tick : rx_var;
    logic [3:0] m0_ff;
    wire        m0_tick  = m0_ff == 4'(spmbc_pkg::MODE0_DIV - 1);
    wire        is_m0    = mode == spmbc_pkg::SPMBC_MODE_SHIFT;
    wire        nine     = ctrl_ff[spmbc_pkg::BIT_MODE_HI];

    ////////////////////////////////////////////////////////////////////////////
    // Transmitter. Writing data happens through a write to the address after clock select while the line idles.
    logic [10:0] tsh_ff;
    logic [3:0]  tbit_ff, tsub_ff;
    logic        tx_busy_ff, txd_ff, tx_done_set;
    logic [7:0]  tdata_ff;
    logic        tstart_ff;
    wire [3:0]   t_last   = nine ? 4'ha : 4'h9;
    wire         t_bitend = is_m0 ? m0_tick : (tx_tick && tsub_ff == 4'hf);
    assign tx_done_set = tx_busy_ff && t_bitend &&
                         (is_m0 ? tbit_ff == 4'h7 : tbit_ff == t_last - 4'h1);

    ////////////////////////////////////////////////////////////////////////////
    // Receiver with a two-stage synchroniser on the pin.
    logic       rxs1_ff, rxs2_ff, rxd_prev_ff;
    logic       r_busy_ff, rx_done_set, rx_nb_set;
    logic [3:0] rbit_ff, rsub_ff;
    logic [8:0] rsh_ff;
    logic [7:0] rx_byte_ff;
    wire        r_sample = rx_tick && rsub_ff == 4'h7;
    wire [3:0]  r_last   = nine ? 4'ha : 4'h9;
    wire        r_stop   = !is_m0 && r_busy_ff && r_sample && rbit_ff == r_last;
    wire        ninth_in = nine ? rsh_ff[8] : rxs2_ff;
    wire        pass     = !filt || (nine ? rsh_ff[8] : rxs2_ff);
    wire        m0_rx_end = is_m0 && r_busy_ff && m0_tick && rbit_ff == 4'h7;
    wire        ri_clear  = !ctrl_ff[spmbc_pkg::BIT_RX_DONE];
    assign rx_done_set = m0_rx_end || (r_stop && pass && ri_clear);
    assign rx_nb_set   = r_stop && pass && ri_clear;
    wire        r_go      = rx_en && !r_busy_ff && (is_m0 ? ri_clear : (rxd_prev_ff && !rxs2_ff));

    ////////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        nxt_ctrl = ctrl_ff;
        if (wr_ctrl)
            nxt_ctrl = bus.wdata;
        if (rx_nb_set)
            nxt_ctrl[spmbc_pkg::BIT_RX_NINTH] = ninth_in;
        if (tx_done_set)
            nxt_ctrl[spmbc_pkg::BIT_TX_DONE] = 1'b1;
        if (rx_done_set)
            nxt_ctrl[spmbc_pkg::BIT_RX_DONE] = 1'b1;
    end

    // Reads of unmapped addresses return zero.
    assign nxt_rdata = !bus.rd ? 8'h00 :
                       sel_ctrl ? ctrl_ff :
                       sel_pwr  ? pwr_ff :
                       sel_csel ? {6'h00, csel_ff} :
                       sel_tdat ? rx_byte_ff : 8'h00;
    // A byte written while a frame is in flight is dropped rather than queued.
    wire wr_tdat  = bus.wr && sel_tdat && !tx_busy_ff;

    always_ff @(posedge CLK)
    begin
        if (!RST_N)
            ctrl_ff <= spmbc_pkg::SERIAL_CTRL_RST;
        else
            ctrl_ff <= nxt_ctrl;
    end

    // Read data stands only in the cycle after each cycle that RD is high, so software must take it at once.
    always_ff @(posedge CLK)
    begin
        if (!RST_N)
            rdata_ff <= 8'h00;
        else
            rdata_ff <= nxt_rdata;
    end

    always_ff @(posedge CLK)
    begin
        if (!RST_N)
            pwr_ff <= spmbc_pkg::POWER_CTRL_RST;
        else if (wr_pwr)
            pwr_ff <= bus.wdata;
    end

    always_ff @(posedge CLK)
    begin
        if (!RST_N)
            csel_ff <= spmbc_pkg::CLK_SEL_RST;
        else if (wr_csel)
            csel_ff <= bus.wdata[1:0];
    end

    ////////////////////////////////////////////////////////////////////////////
    // Prescalers run freely, so a frame may start at any phase of its tick.
    always_ff @(posedge CLK)
    begin
        if (!RST_N)
        begin
            pre_ff <= 6'h00;
            m0_ff  <= 4'h0;
        end
        else
        begin
            pre_ff <= osc_top ? 6'h00 : pre_ff + 6'h01;
            m0_ff  <= m0_tick ? 4'h0 : m0_ff + 4'h1;
        end
    end

    // Without the doubler only every second timer 1 overflow makes a tick.
    always_ff @(posedge CLK)
    begin
        if (!RST_N)
            t1_half_ff <= 1'b0;
        else if (T1_OVF)
            t1_half_ff <= !t1_half_ff;
    end

    ////////////////////////////////////////////////////////////////////////////
    // A second write before the start takes effect replaces the pending byte.
    always_ff @(posedge CLK)
    begin
        if (!RST_N)
        begin
            tstart_ff <= 1'b0;
            tdata_ff  <= 8'h00;
        end
        else if (wr_tdat)
        begin
            tdata_ff  <= bus.wdata;
            tstart_ff <= 1'b1;
        end
        else if (tstart_ff)
            tstart_ff <= 1'b0;
    end

    always_ff @(posedge CLK)
    begin
        if (!RST_N)
        begin
            tx_busy_ff <= 1'b0;
            tsh_ff     <= 11'h7ff;
            tbit_ff    <= 4'h0;
            tsub_ff    <= 4'h0;
            txd_ff     <= 1'b1;
        end
        else if (tstart_ff && !wr_tdat)
        begin
            tx_busy_ff <= 1'b1;
            tbit_ff    <= 4'h0;
            tsub_ff    <= 4'h0;
            tsh_ff     <= is_m0 ? {3'h7, tdata_ff} :
                          {1'b1, ctrl_ff[spmbc_pkg::BIT_TX_NINTH], tdata_ff, 1'b0};
        end
        else if (tx_busy_ff)
        begin
            if (!is_m0 && tx_tick)
                tsub_ff <= tsub_ff + 4'h1;
            txd_ff <= is_m0 ? m0_ff < 4'(spmbc_pkg::MODE0_DIV / 2) : tsh_ff[0];
            if (t_bitend)
            begin
                tsh_ff  <= {1'b1, tsh_ff[10:1]};
                tbit_ff <= tbit_ff + 4'h1;
                if (is_m0 ? tbit_ff == 4'h7 : tbit_ff == t_last)
                    tx_busy_ff <= 1'b0;
            end
        end
        else
            txd_ff <= 1'b1;
    end

    always_ff @(posedge CLK)
    begin
        if (!RST_N)
        begin
            rxs1_ff     <= 1'b1;
            rxs2_ff     <= 1'b1;
            rxd_prev_ff <= 1'b1;
        end
        else
        begin
            rxs1_ff     <= RXD_IN;
            rxs2_ff     <= rxs1_ff;
            rxd_prev_ff <= rxs2_ff;
        end
    end

    always_ff @(posedge CLK)
    begin
        if (!RST_N)
            rx_byte_ff <= 8'h00;
        else if (m0_rx_end)
            rx_byte_ff <= {rxs2_ff, rsh_ff[7:1]};
        else if (rx_nb_set)
            rx_byte_ff <= rsh_ff[7:0];
    end

    always_ff @(posedge CLK)
    begin
        if (!RST_N)
        begin
            r_busy_ff <= 1'b0;
            rbit_ff   <= 4'h0;
            rsub_ff   <= 4'h0;
            rsh_ff    <= 9'h000;
        end
        else if (r_go)
        begin
            r_busy_ff <= 1'b1;
            rbit_ff   <= 4'h0;
            rsub_ff   <= 4'h0;
        end
        else if (r_busy_ff && is_m0)
        begin
            if (m0_tick)
            begin
                rsh_ff  <= {1'b0, rxs2_ff, rsh_ff[7:1]};
                rbit_ff <= rbit_ff + 4'h1;
                if (rbit_ff == 4'h7)
                    r_busy_ff <= 1'b0;
            end
        end
        else if (r_busy_ff)
        begin
            if (rx_tick)
                rsub_ff <= rsub_ff + 4'h1;
            if (r_sample)
            begin
                rbit_ff <= rbit_ff + 4'h1;
                // A start bit that reads high at mid-bit is noise, so the search restarts.
                if (rbit_ff == 4'h0 && rxs2_ff)
                    r_busy_ff <= 1'b0;
                else if (rbit_ff != 4'h0 && rbit_ff != r_last)
                    rsh_ff <= nine ? {rxs2_ff, rsh_ff[8:1]} : {1'b0, rxs2_ff, rsh_ff[7:1]};
                // The stop bit is sampled but never shifted into the data register.
                if (rbit_ff == r_last)
                    r_busy_ff <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // The pin enable is registered, so it trails the shifter by one cycle.
    logic oe_n_ff;
    wire  nxt_oe_n = !(is_m0 && tx_busy_ff);

    always_ff @(posedge CLK)
    begin
        if (!RST_N)
            oe_n_ff <= 1'b1;
        else
            oe_n_ff <= nxt_oe_n;
    end

    assign RDATA    = rdata_ff;
    assign TXD      = txd_ff;
    // In mode 0 the data pin is driven by transmit shifting; otherwise it only listens.
    assign RXD_OUT  = tsh_ff[0];
    assign RXD_OE_N = oe_n_ff;
endmodule
`default_nettype wire

// *** tb/spmbc_serial_port_sva.sv ***
// Checker for the register port and pin behaviour of the serial port.
// Assumes software does not change the mode bits while a frame is in flight.
`timescale 1ns/1ps
`default_nettype none
module spmbc_serial_port_sva (
    input wire logic       CLK,
    input wire logic       RST_N,
    input wire logic [7:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic       WR,
    input wire logic       RD,
    input wire logic [7:0] RDATA,
    input wire logic       RXD_OE_N,
    input wire logic       TXD
);
    logic       rd_ff;
    logic [7:0] ra_ff;
    logic [7:0] sc_ff;
    logic       pc_ff;
    logic [1:0] cs_ff;
    logic [1:0] seen_ff;
    wire logic  wr_sc = WR && (ADDR == spmbc_pkg::SERIAL_CTRL_ADDR);
    wire logic  wr_pc = WR && (ADDR == spmbc_pkg::POWER_CTRL_ADDR);
    wire logic  wr_cs = WR && (ADDR == spmbc_pkg::CLK_SEL_ADDR);
    wire logic  rd_sc = rd_ff && (ra_ff == spmbc_pkg::SERIAL_CTRL_ADDR);
    wire logic  rd_pc = rd_ff && (ra_ff == spmbc_pkg::POWER_CTRL_ADDR);
    wire logic  rd_cs = rd_ff && (ra_ff == spmbc_pkg::CLK_SEL_ADDR);
    wire logic  rd_un = rd_ff && !(ra_ff inside {8'h98, 8'h87, 8'hc8, 8'hc9});
    // Flags seen set stay set until software writes the register, since hardware never clears them.
    always_ff @(posedge CLK)
    begin
        if (!RST_N)
            {rd_ff, ra_ff, sc_ff, pc_ff, cs_ff, seen_ff} <= '0;
        else
        begin
            rd_ff <= RD;
            ra_ff <= ADDR;
            sc_ff <= wr_sc ? WDATA : sc_ff;
            pc_ff <= wr_pc ? WDATA[7] : pc_ff;
            cs_ff <= wr_cs ? WDATA[1:0] : cs_ff;
            seen_ff <= wr_sc ? 2'h0 : (rd_sc ? (seen_ff | RDATA[1:0]) : seen_ff);
        end
    end
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_N);
    a_rdata_idle: assert property (!rd_ff |-> RDATA == 8'h00)
        else $error("read data not zero outside read slot");
    a_unmapped_zero: assert property (rd_un |-> RDATA == 8'h00)
        else $error("unmapped read not zero");
    a_mode_readback: assert property (rd_sc |-> RDATA[7:3] == sc_ff[7:3])
        else $error("control register software bits lost");
    a_doubler_readback: assert property (rd_pc |-> RDATA[7] == pc_ff)
        else $error("doubler bit lost");
    a_clksel_readback: assert property (rd_cs |-> RDATA[1:0] == cs_ff)
        else $error("clock select bits lost");
    a_flags_sticky: assert property (rd_sc |-> (RDATA[1:0] & seen_ff) == seen_ff)
        else $error("done flag cleared by hardware");
    a_pin_mode0: assert property (!RXD_OE_N |-> sc_ff[7:6] == 2'h0)
        else $error("data pin driven outside shift mode");
    a_txd_release: assert property ($rose(RST_N) |-> TXD ##1 TXD)
        else $error("serial out not idle after reset");
    cover property (rd_sc && RDATA[0]);
    cover property (rd_sc && RDATA[1]);
    cover property ($fell(TXD));
endmodule
bind spmbc_serial_port spmbc_serial_port_sva u_sva (.CLK(CLK), .RST_N(RST_N), .ADDR(ADDR), .WDATA(WDATA),
    .WR(WR), .RD(RD), .RDATA(RDATA), .RXD_OE_N(RXD_OE_N), .TXD(TXD));
`default_nettype wire

// *** tb/spmbc_uart_node.sv ***
// Remote serial node that sends frames, first bit first, on the receive line.
// Assumes the line has a pull-up, so it rests high between frames.
`timescale 1ns/1ps
`default_nettype none
module spmbc_uart_node (
    input  wire logic CLK,
    output logic      LINE
);
    initial LINE = 1'b1;
    task automatic send(input logic [10:0] f, input int n, input int bc);
        for (int i = 0; i < n; i++)
        begin
            LINE <= f[i];
            repeat (bc) @(posedge CLK);
        end
        LINE <= 1'b1;
    endtask
endmodule
`default_nettype wire

// *** tb/tb_spmbc_serial_port.sv ***
// Self-checking bench for the serial port block.
// Timer overflows pulse every second cycle, so one timer tick is two clocks.
`timescale 1ns/1ps
`default_nettype none
module tb_spmbc_serial_port;
    logic       CLK = 1'b0, RST_N = 1'b0, WR = 1'b0, RD = 1'b0, T1_OVF = 1'b0, T2_OVF = 1'b0;
    logic [7:0] ADDR = 8'h00, WDATA = 8'h00;
    wire logic [7:0] RDATA;
    wire logic  RXD_OUT, RXD_OE_N, TXD, line;
    wire logic  rxd = !RXD_OE_N ? RXD_OUT : line;
    int         fail_count = 0, n_tests = 0;
    always #2 CLK = ~CLK;
    always @(posedge CLK)
    begin
        T1_OVF <= ~T1_OVF;
        T2_OVF <= ~T2_OVF;
    end
    spmbc_uart_node node (.CLK(CLK), .LINE(line));
    spmbc_serial_port dut (.CLK(CLK), .RST_N(RST_N), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
        .RDATA(RDATA), .T1_OVF(T1_OVF), .T2_OVF(T2_OVF), .RXD_IN(rxd), .RXD_OUT(RXD_OUT),
        .RXD_OE_N(RXD_OE_N), .TXD(TXD));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge CLK);
        {WR, ADDR, WDATA} <= {1'b1, a, d};
        @(posedge CLK);
        WR <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge CLK);
        {RD, ADDR} <= {1'b1, a};
        @(posedge CLK);
        RD <= 1'b0;
        @(negedge CLK);
        d = RDATA;
    endtask
    task automatic chk(input logic [7:0] s, input logic [7:0] e);
        n_tests++;
        if (s !== e)
        begin
            fail_count++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    // Filter bit is set by some callers; shift mode is never entered by this task.
    task automatic rx(input logic [7:0] sc, pc, cs, input logic [10:0] f, input int n, bc,
                      input logic [1:0] e, input logic [7:0] ed);
        logic [7:0] d;
        wr(8'h87, pc);
        wr(8'hc8, cs);
        wr(8'h98, sc);
        node.send(f, n, bc);
        repeat (2 * bc) @(posedge CLK);
        rd(8'h98, d);
        chk({6'h00, d[2] & e[0], d[0]}, {6'h00, e});
        if (e[0])
        begin
            rd(8'hc9, d);
            chk(d, ed);
        end
    endtask
    task automatic tx(input logic [7:0] pc, input int e);
        int w;
        logic [7:0] d;
        wr(8'h87, pc);
        wr(8'hc8, 8'h00);
        wr(8'h98, 8'h40);
        wr(8'hc9, 8'hff);
        for (w = 0; TXD !== 1'b0 && w < 400; w++) @(posedge CLK);
        for (w = 0; TXD === 1'b0 && w < 400; w++) @(posedge CLK);
        chk({7'h00, w >= e - 2 && w <= e + 2}, 8'h01);
        rd(8'h98, d);
        chk({7'h00, d[1]}, 8'h00);
        repeat (10 * e) @(posedge CLK);
        rd(8'h98, d);
        chk({7'h00, d[1]}, 8'h01);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_regs;
        logic [7:0] d;
        rd(8'h98, d);
        chk(d, spmbc_pkg::SERIAL_CTRL_RST);
        rd(8'h55, d);
        chk(d, 8'h00);
        wr(8'h87, 8'h80);
        rd(8'h87, d);
        chk({d[7], 7'h00}, 8'h80);
        $display("t_regs done");
    endtask
    task automatic t_fixed;
        rx(8'hb0, 8'h80, 8'h00, {2'b10, 8'ha5, 1'b0}, 11, 32, 2'b00, 8'h00);
        rx(8'hb0, 8'h80, 8'h00, {2'b11, 8'h3c, 1'b0}, 11, 32, 2'b11, 8'h3c);
        rx(8'h90, 8'h00, 8'h00, {2'b11, 8'hc3, 1'b0}, 11, 64, 2'b11, 8'hc3);
        rx(8'h80, 8'h80, 8'h00, {2'b11, 8'h0f, 1'b0}, 11, 32, 2'b00, 8'h00);
        $display("t_fixed done");
    endtask
    task automatic t_var;
        rx(8'h70, 8'h00, 8'h02, {1'b0, 8'h81, 1'b0}, 10, 32, 2'b00, 8'h00);
        rx(8'h50, 8'h00, 8'h02, {1'b1, 8'h5a, 1'b0}, 10, 32, 2'b11, 8'h5a);
        rx(8'hd0, 8'h00, 8'h02, {2'b10, 8'h66, 1'b0}, 11, 32, 2'b01, 8'h66);
        $display("t_var done");
    endtask
    task automatic t_txrate;
        tx(8'h00, 64);
        tx(8'h80, 32);
        $display("t_txrate done");
    endtask
    task automatic complete_run;
        $display("tests=%0d mismatches=%0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (5) @(posedge CLK);
        RST_N <= 1'b1;
        t_regs;
        t_fixed;
        t_var;
        t_txrate;
        complete_run;
    end
    // The full sequence needs about 4500 cycles; over six times that means a hang.
    initial
    begin
        repeat (30000) @(posedge CLK);
        fail_count++;
        complete_run;
    end
endmodule
`default_nettype wire
